/* rwit_pkg.sv */
// Package of constants and types for the runaway watchdog / interval timer.
package rwit_pkg;

  // ----------------------------------------------------------------
  // Register reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RWIT_MODE_RST = 8'h00; // Mode register after reset.
  localparam logic [2:0] RWIT_CSEL_RST = 3'h0;  // Count-select field after reset.

  // ----------------------------------------------------------------
  // Mode register field positions
  // ----------------------------------------------------------------
  localparam int RWIT_RUN_POS = 7; // Run bit.
  localparam int RWIT_WDM_POS = 4; // Watchdog-mode bit.
  localparam int RWIT_RSS_POS = 3; // Reset-select bit.

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int RWIT_CNT_W    = 20; // Counter width, covers 2^19 main clock periods.
  localparam int RWIT_EXP_BASE = 11; // Exponent for code 000.
  localparam int RWIT_EXP_TOP  = 19; // Exponent for code 111.
  localparam logic [2:0] RWIT_CODE_TOP = 3'h7; // Code for the longest period.

  // Operating mode of the timer.
  typedef enum logic [0:0] {
    RWIT_INTERVAL = 1'b0,
    RWIT_WATCHDOG = 1'b1
  } rwit_mode_t;

endpackage : rwit_pkg

/* rwit_top.sv */
// Runaway watchdog and interval timer, single clock domain.
`timescale 1ns/1ps
`default_nettype none

module rwit_top
  import rwit_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Oscillator clock tick, one pulse per oscillator period, from this clock domain.
  input  wire logic       osc_clk_tick,
  // Mode register write port.
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wdata,
  // Shared clock select register write port, count-select field only.
  input  wire logic       csel_wr,
  input  wire logic [2:0] csel_wdata,
  // Oscillator divide bit and processor state.
  input  wire logic       osc_divide_bit,
  input  wire logic       cpu_stop,
  input  wire logic       cpu_on_subclk,
  // Interrupt controller side.
  input  wire logic       timer_irq_mask,
  input  wire logic       timer_irq_priority,
  input  wire logic       timer_irq_flag_clr,
  // Outputs.
  output logic [7:0]      wd_mode_reg,
  output logic [2:0]      shared_clock_select_reg,
  output logic            timer_irq_flag,
  output logic            interval_irq,
  output logic            interval_irq_high_prio,
  output logic            nmi_pulse,
  output logic            sys_reset_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                  run_q, run_d;          // Counting enabled.
  rwit_mode_t            mode_q, mode_d;        // Interval or watchdog.
  logic                  rsel_q, rsel_d;        // Reset-select bit.
  logic [2:0]            csel_q, csel_d;        // Count-select field.
  logic                  pre_q, pre_d;          // Divide-by-two prescaler, cleared only by reset.
  logic [RWIT_CNT_W-1:0] cnt_q, cnt_d;          // Main count.
  logic                  flag_q, flag_d;        // Timer interrupt request flag.
  logic                  nmi_q, nmi_d;          // NMI pulse register.
  logic                  rst_q, rst_d;          // System reset pulse register.
  logic                  tick;                  // One main system clock period.
  logic                  ovf;                   // Counter reaches the selected period.
  logic [RWIT_CNT_W-1:0] limit;                 // Last count before overflow.

  // ----------------------------------------------------------------
  // Period selection
  // ----------------------------------------------------------------
  // Code 111 skips 2^18 and selects 2^19.
  always_comb
  begin
    if (csel_q == RWIT_CODE_TOP)
    begin
      limit = RWIT_CNT_W'((1 << RWIT_EXP_TOP) - 1);
    end
    else
    begin
      limit = RWIT_CNT_W'((1 << (RWIT_EXP_BASE + int'(csel_q))) - 1);
    end
  end

  // Main system clock tick: every oscillator tick, or every second one. The
  // prescaler is not cleared by a restart, so the first period may run short.
  assign tick = osc_clk_tick && (osc_divide_bit || pre_q)
                && !cpu_stop && !cpu_on_subclk;
  assign ovf  = run_q && tick && (cnt_q == limit);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    run_d  = run_q;
    mode_d = mode_q;
    rsel_d = rsel_q;
    csel_d = csel_q;
    pre_d  = pre_q;
    cnt_d  = cnt_q;
    flag_d = flag_q;
    nmi_d  = 1'b0;
    rst_d  = 1'b0;
    // Prescaler keeps running on the oscillator while the core is neither stopped nor on the subclock.
    if (osc_clk_tick && !cpu_stop && !cpu_on_subclk)
    begin
      pre_d = !pre_q;
    end
    // Counting only while running.
    if (run_q && tick)
    begin
      cnt_d = ovf ? '0 : cnt_q + 1'b1;
    end
    // Overflow effects by mode.
    if (ovf && mode_q == RWIT_WATCHDOG)
    begin
      nmi_d = !rsel_q;
      rst_d = rsel_q;
    end
    // A new interval overflow wins over a clear in the same cycle.
    if (ovf && mode_q == RWIT_INTERVAL)
    begin
      flag_d = 1'b1;
    end
    else if (timer_irq_flag_clr)
    begin
      flag_d = 1'b0;
    end
    // Software writes; only setting is honoured on sticky bits.
    if (mode_wr)
    begin
      if (mode_wdata[RWIT_RUN_POS])
      begin
        run_d = 1'b1;
        cnt_d = '0;
      end
      if (mode_wdata[RWIT_WDM_POS])
      begin
        mode_d = RWIT_WATCHDOG;
        if (mode_q == RWIT_INTERVAL && flag_q)
        begin
          nmi_d = 1'b1;
        end
      end
      if (mode_wdata[RWIT_RSS_POS])
      begin
        rsel_d = 1'b1;
      end
    end
    if (csel_wr)
    begin
      csel_d = csel_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run_q  <= RWIT_MODE_RST[RWIT_RUN_POS];
      mode_q <= RWIT_INTERVAL;
      rsel_q <= RWIT_MODE_RST[RWIT_RSS_POS];
      csel_q <= RWIT_CSEL_RST;
      pre_q  <= 1'b0;
      cnt_q  <= '0;
      flag_q <= 1'b0;
      nmi_q  <= 1'b0;
      rst_q  <= 1'b0;
    end
    else
    begin
      run_q  <= run_d;
      mode_q <= mode_d;
      rsel_q <= rsel_d;
      csel_q <= csel_d;
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
      nmi_q  <= nmi_d;
      rst_q  <= rst_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wd_mode_reg             = {run_q, 2'b00, mode_q == RWIT_WATCHDOG, rsel_q, 3'b000};
  assign shared_clock_select_reg = csel_q;
  assign timer_irq_flag          = flag_q;
  // Mask and priority apply only in interval mode.
  assign interval_irq            = flag_q && !timer_irq_mask && (mode_q == RWIT_INTERVAL);
  // Highest default priority: raised with the request only while the priority bit is 0.
  assign interval_irq_high_prio  = interval_irq && !timer_irq_priority;
  assign nmi_pulse               = nmi_q;
  assign sys_reset_pulse         = rst_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  stopped_holds_a: assert property (@(posedge clk) disable iff (srst)
    !run_q |=> $stable(cnt_q)) else $error("Counter moved while stopped.");
  run_sticky_a: assert property (@(posedge clk) disable iff (srst)
    run_q |=> run_q) else $error("Run bit cleared.");
  mode_sticky_a: assert property (@(posedge clk) disable iff (srst)
    mode_q == RWIT_WATCHDOG |=> mode_q == RWIT_WATCHDOG) else $error("Mode bit cleared.");
  wd_nmi_a: assert property (@(posedge clk) disable iff (srst)
    ovf && mode_q == RWIT_WATCHDOG && !rsel_q |=> nmi_q) else $error("Missing NMI.");
  wd_reset_a: assert property (@(posedge clk) disable iff (srst)
    ovf && mode_q == RWIT_WATCHDOG && rsel_q |=> rst_q && !nmi_q) else $error("Missing reset.");
  int_flag_a: assert property (@(posedge clk) disable iff (srst)
    ovf && mode_q == RWIT_INTERVAL |=> flag_q && cnt_q == '0) else $error("Interval overflow lost.");
  late_mode_a: assert property (@(posedge clk) disable iff (srst)
    mode_wr && mode_wdata[RWIT_WDM_POS] && mode_q == RWIT_INTERVAL && flag_q |=> nmi_q)
    else $error("Pending flag gave no NMI.");
  stop_freeze_a: assert property (@(posedge clk) disable iff (srst)
    (cpu_stop || cpu_on_subclk) && !mode_wr |=> $stable(cnt_q)) else $error("Count in stop.");
  pulse_one_a: assert property (@(posedge clk) disable iff (srst)
    rst_q |=> !rst_q) else $error("Reset pulse too long.");
  mask_gate_a: assert property (@(posedge clk) disable iff (srst)
    interval_irq |-> mode_q == RWIT_INTERVAL && !timer_irq_mask) else $error("Ungated request.");

endmodule : rwit_top

`default_nettype wire

/* rwit_core_model.sv */
// Model of the core reset and interrupt controller beside the timer.
`timescale 1ns/1ps
`default_nettype none

module rwit_core_model (
  // Clock and timer requests.
  input  wire logic clk,
  input  wire logic interval_irq,
  input  wire logic sys_reset_pulse,
  // Flag acknowledge and core reset.
  output var  logic flag_clr_q,
  output var  logic core_rst
);
  logic [1:0] rst_left_q = 2'h0; // Core reset cycles still to run.
  // A granted request is acknowledged once; masked ones are left pending.
  // The acknowledge settles during the bench reset, so it needs no start value.
  always @(posedge clk)
  begin
    flag_clr_q <= interval_irq && !flag_clr_q;
    rst_left_q <= sys_reset_pulse ? 2'h3 : rst_left_q - {1'b0, |rst_left_q};
  end
  // The reset pulse holds the whole device in reset for three cycles.
  assign core_rst = |rst_left_q;
endmodule : rwit_core_model

`default_nettype wire

/* rwit_top_bench.sv */
// Self-checking bench for the watchdog and interval timer.
`timescale 1ns/1ps
`default_nettype none

module rwit_top_bench
  import rwit_pkg::*;
;
  logic clk, srst_b, tick, mwr, cwr, div, stp, sub, msk, pri, fl_p = 1'b0;
  logic [7:0] mdat;
  logic [2:0] cdat;
  wire logic [7:0] mreg;
  wire logic [2:0] csel_v;
  wire logic flag, irq, hip, nmi, rstp, clr, crst;
  wire logic srst = srst_b | crst; // Bench reset or core reset.
  int fails = 0, checked = 0, cyc = 0, seed = 32'hc566bece, i, n;
  logic [1:0] kq[$]; // Expected event kinds, oldest first.
  int eq[$];         // Expected cycles since the last restart or event.

  rwit_top u_rwit_top (.clk(clk), .srst(srst), .osc_clk_tick(tick), .mode_wr(mwr), .mode_wdata(mdat),
    .csel_wr(cwr), .csel_wdata(cdat), .osc_divide_bit(div), .cpu_stop(stp), .cpu_on_subclk(sub),
    .timer_irq_mask(msk), .timer_irq_priority(pri), .timer_irq_flag_clr(clr), .wd_mode_reg(mreg),
    .shared_clock_select_reg(csel_v), .timer_irq_flag(flag), .interval_irq(irq),
    .interval_irq_high_prio(hip), .nmi_pulse(nmi), .sys_reset_pulse(rstp));
  rwit_core_model u_rwit_core_model (.clk(clk), .interval_irq(irq), .sys_reset_pulse(rstp),
    .flag_clr_q(clr), .core_rst(crst));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic cmp_v8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp_v8

  // Events must match the oldest note within four cycles; the first period may run short.
  task automatic cmp_evt(input logic [1:0] k, input int el);
    checked++;
    if (kq.size() == 0 || k !== kq[0] || el < eq[0] - 4 || el > eq[0] + 4)
    begin
      fails++;
      $display("wrong value at %0t: event %0d after %0d cycles", $time, k, el);
    end
    if (kq.size() != 0)
    begin
      kq.pop_front();
      eq.pop_front();
    end
  endtask : cmp_evt

  // The watcher times every event from the last run write or the last event.
  always @(posedge clk)
  begin
    fl_p <= flag;
    cyc <= ((mwr && mdat[7]) || nmi || rstp || (flag && !fl_p)) ? 0 : cyc + 1;
    if (flag && !fl_p)
    begin
      cmp_evt(2'h1, cyc);
      cmp_v8({6'h0, irq, hip}, {6'h0, !msk, !msk && !pri});
    end
    if (nmi)
      cmp_evt(2'h2, cyc);
    if (rstp)
      cmp_evt(2'h3, cyc);
  end

  task automatic wr_mode(input logic [7:0] v);
    @(negedge clk);
    mwr = 1'b1;
    mdat = v;
    @(negedge clk);
    mwr = 1'b0;
  endtask : wr_mode

  task automatic wr_csel(input logic [2:0] v);
    @(negedge clk);
    cwr = 1'b1;
    cdat = v;
    @(negedge clk);
    cwr = 1'b0;
  endtask : wr_csel

  task automatic wait_q(input int k);
    for (int j = 0; j < 20000 && kq.size() > k; j++) @(negedge clk);
    if (kq.size() > k)
    begin
      fails++;
      $display("wrong value at %0t: event missing", $time);
      summarize();
    end
  endtask : wait_q

  // Two interval periods; the first may be stretched by a stop or subclock stall.
  task automatic run_int(input logic [2:0] code, input logic d, input int stall);
    int p;
    p = (1 << (RWIT_EXP_BASE + code)) * (d ? 1 : 2);
    {pri, msk} = 2'($random(seed));
    div = d;
    wr_csel(code);
    wr_mode(8'h80);
    kq.push_back(2'h1);
    eq.push_back(p + stall);
    kq.push_back(2'h1);
    eq.push_back(p);
    repeat (100) @(negedge clk);
    stp = stall[0];
    sub = !stall[0] && stall > 0;
    // The oscillator tick wanders while stalled; the count must not care.
    repeat (stall)
    begin
      tick = 1'($random(seed));
      @(negedge clk);
    end
    tick = 1'b1;
    stp = 1'b0;
    sub = 1'b0;
    wait_q(1);
    msk = 1'b0;
    wait_q(0);
  endtask : run_int

  initial
  begin
    srst_b = 1'b1;
    tick = 1'b1;
    {mwr, cwr, stp, sub, msk, pri} = 6'h00;
    div = 1'b1;
    mdat = 8'h00;
    cdat = 3'h0;
    repeat (3) @(negedge clk);
    srst_b = 1'b0;
    cmp_v8(mreg, 8'h00);
    cmp_v8({5'h0, csel_v}, 8'h00);
    repeat (2100) @(negedge clk);
    for (i = 0; i < 3; i++) run_int(i[2:0], 1'b1, 0);
    run_int(3'h0, 1'b0, 0);
    n = $random(seed) & 31;
    run_int(3'h0, 1'b1, 2 * n + 1);
    run_int(3'h0, 1'b1, 2 * n + 2);
    // A masked flag is left pending before watchdog mode is entered.
    msk = 1'b1;
    wr_mode(8'h80);
    kq.push_back(2'h1);
    eq.push_back(2048);
    wait_q(0);
    kq.push_back(2'h2);
    eq.push_back(1);
    kq.push_back(2'h2);
    eq.push_back(2048);
    wr_mode(8'h90);
    wr_mode(8'h00);
    cmp_v8(mreg, 8'h90);
    msk = 1'b0;
    @(negedge clk);
    cmp_v8({6'h0, flag, irq}, 8'h02);
    wait_q(0);
    repeat (3)
    begin
      repeat (1500) @(negedge clk);
      wr_mode(8'h80);
    end
    wr_csel(3'h1);
    kq.push_back(2'h3);
    eq.push_back(4096);
    wr_mode(8'h88);
    wait_q(0);
    repeat (6) @(negedge clk);
    cmp_v8(mreg, 8'h00);
    cmp_v8({5'h0, csel_v}, 8'h00);
    // The longest code is too slow to time here; its selection is read back.
    wr_csel(RWIT_CODE_TOP);
    cmp_v8({5'h0, csel_v}, 8'h07);
    summarize();
  end
endmodule : rwit_top_bench

`default_nettype wire
